// [shared/psio_consts.svh]
// register offsets, field positions, reset values and opcode constants for the pointer-subtract decoder
// Functional notes
// RULE_01: The pointer-subtract opcode takes its 6-bit literal from its low bits off the pointer picked by its two-bit field (0, 1 or 2) and writes the result back there.
// RULE_02: Pointer-subtract changes no arithmetic flag, is one program word long and finishes in one instruction cycle.
// RULE_03: A pointer-select field of binary 11 turns the opcode into subtract-and-return, which always works on the frame pointer.
// RULE_04: Subtract-and-return takes the literal off the frame pointer, loads the program counter from the top of the return stack, and then spends a second cycle doing nothing.
// RULE_05: One enable switches on the extended set and indexed literal offset addressing together, so that neither is ever on alone.
// Here the enable gates only indexed addressing; pointer-subtract runs whatever its value.
// RULE_06: With the extended set off, a file operand is literal: an Access Bank location when the access bit is 0, or a location in the bank chosen by the bank select register when it is 1.
// RULE_07: With the extended set on and the access bit 0, a byte or bit instruction with a file operand of 5Fh or less reaches the frame pointer plus that operand.
// RULE_08: With the extended set on, a file operand above 5Fh keeps its plain literal meaning.
// RULE_09: A frame pointer of 00h makes indexed accesses land on the same low Access RAM locations as standard mode.
// RULE_10: In indexed mode the destination-select bit of byte instructions means what it means with the extended set off.
// RULE_11: In indexed mode a destination-select bit of 0 sends the result to the working register and 1 sends it to the indexed location.
// RULE_12: The enable for the extended set and indexed addressing resets to 0, leaving both off. Here pointer-subtract still runs with it at 0.
// RULE_13: The pointer subtraction runs over the whole pointer, carrying the borrow from the low byte into the high part.
`ifndef PSIO_CONSTS_SVH
`define PSIO_CONSTS_SVH

`define PSIO_OFS_CTRL       8'h00
`define PSIO_OFS_INSN       8'h04
`define PSIO_OFS_PTR0       8'h08
`define PSIO_OFS_PTR1       8'h0c
`define PSIO_OFS_PTR2       8'h10
`define PSIO_OFS_STACK_TOP  8'h14
`define PSIO_OFS_PC         8'h18
`define PSIO_OFS_BANK_SEL   8'h1c
`define PSIO_OFS_STATUS     8'h20
`define PSIO_OFS_EA         8'h24

`define PSIO_CTRL_EXT_BIT   0
`define PSIO_CTRL_RESET     1'h0
`define PSIO_ST_BUSY_BIT    8
`define PSIO_ST_RET_BIT     9
`define PSIO_EA_IDX_BIT     16
`define PSIO_EA_DESTW_BIT   17
`define PSIO_EA_VALID_BIT   18

`define PSIO_PTR_W          12
`define PSIO_PC_W           21
`define PSIO_FLAGS_W        5
`define PSIO_OP_SUBPTR      8'he9
`define PSIO_SEL_FRAME      2'h3
`define PSIO_FRAME_IDX      2'h2
`define PSIO_IDX_LIMIT      8'h5f
`define PSIO_SFR_PAGE       4'hf
`define PSIO_Q_LAST         2'h3

`endif

// [shared/psio_pkg.sv]
// types and opcode decoding shared by the pointer-subtract decoder modules
package psio_pkg;

    typedef enum logic [1:0] {
        PSIO_IDLE,
        PSIO_WAIT,
        PSIO_EXEC,
        PSIO_NOP
    } psio_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } psio_wb_req_t;

    typedef struct packed {
        logic        valid;
        logic        dest_w;
        logic        indexed;
        logic [11:0] addr;
    } psio_ea_t;

    // opcodes that carry an access bit and an 8-bit file operand
    function automatic logic psio_is_file_op(input logic [15:0] op);
        psio_is_file_op = ((op[15:12] >= 4'h1) && (op[15:12] <= 4'hb) && (op[15:12] != 4'h9 || op[15:8] != 8'h00))
                          || (op[15:9] == 7'h01) || (op[15:10] == 6'h01);
    endfunction

    // byte instructions whose bit 9 selects working register or file
    function automatic logic psio_has_dest(input logic [15:0] op);
        psio_has_dest = ((op[15:12] >= 4'h1) && (op[15:12] <= 4'h5)) || (op[15:10] == 6'h01);
    endfunction

endpackage

// [rtl/psio_addr_map.sv]
// resolves the data address of a byte or bit instruction's file operand
`timescale 1ns/100ps
`include "psio_consts.svh"
module psio_addr_map (
    input  wire logic [15:0]          opcode_i,
    input  wire logic                 ext_en_i,
    input  wire logic [3:0]           bank_sel_i,
    input  wire logic [11:0]          frame_ptr_i,
    output psio_pkg::psio_ea_t        ea_o
);
    logic       access_bit;
    logic [7:0] operand;

    assign access_bit = opcode_i[8];
    assign operand    = opcode_i[7:0];

    always_comb begin
        ea_o         = '0;
        ea_o.valid   = psio_pkg::psio_is_file_op(opcode_i);
        // destination bit behaves identically in both modes
        ea_o.dest_w  = psio_pkg::psio_has_dest(opcode_i) & ~opcode_i[9]; // see RULE_10 see RULE_11
        if (ext_en_i && !access_bit && operand <= `PSIO_IDX_LIMIT) begin
            // a zero frame pointer yields the plain low access ram address
            ea_o.addr    = frame_ptr_i + {4'h0, operand}; // see RULE_07 see RULE_09
            ea_o.indexed = 1'b1;
        end else if (!access_bit) begin
            // upper operands stay literal even with the extended set on
            if (operand <= `PSIO_IDX_LIMIT) begin
                ea_o.addr = {4'h0, operand}; // see RULE_06 see RULE_08
            end else begin
                ea_o.addr = {`PSIO_SFR_PAGE, operand}; // see RULE_06 see RULE_08
            end
        end else begin
            ea_o.addr = {bank_sel_i, operand}; // see RULE_06
        end
    end
endmodule

// [rtl/psio_top.sv]
// pointer-subtract, subtract-and-return and indexed offset decode with a classic wishbone register slave
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`include "psio_consts.svh"
module psio_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o,
    output logic             ext_en_o,
    output logic      [20:0] pc_o,
    output logic      [11:0] ea_addr_o,
    output logic             ea_valid_o
);
    psio_pkg::psio_wb_req_t req;
    psio_pkg::psio_state_t  state_reg;
    psio_pkg::psio_state_t  state_next;
    psio_pkg::psio_ea_t     ea_comb;
    psio_pkg::psio_ea_t     ea_reg;

    logic [1:0]               q_reg;
    logic                     q4;
    logic                     ext_en_reg;
    logic [15:0]              insn_reg;
    logic [`PSIO_PTR_W-1:0]   ptr_reg [3];
    logic [`PSIO_PC_W-1:0]    stack_top_reg;
    logic [`PSIO_PC_W-1:0]    pc_reg;
    logic [3:0]               bank_sel_reg;
    logic [`PSIO_FLAGS_W-1:0] flags_reg;
    logic                     ret_reg;
    logic                     ack_reg;
    logic [31:0]              rdat_reg;
    logic [31:0]              rdat_next;
    logic                     wr_en;
    logic                     rd_en;
    logic                     start;

    logic                     is_subptr;
    logic [1:0]               sel_field;
    logic [1:0]               tgt_idx;
    logic [5:0]               lit;
    logic [`PSIO_PTR_W-1:0]   sub_result;
    logic [7:0]               lo_diff;
    logic                     lo_borrow;

    // byte-lane merge for partial wishbone writes
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        wb_merge = res;
    endfunction

    function automatic logic wr_hit(input psio_pkg::psio_wb_req_t r, input logic en, input logic [7:0] ofs);
        wr_hit = en && (r.adr[7:2] == ofs[7:2]);
    endfunction

    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we  = wb_we_i;
    assign req.adr = wb_adr_i;
    assign req.sel = wb_sel_i;
    assign req.dat = wb_dat_i;

    // one access per request; ack drops the cycle after it rises
    assign wr_en = req.cyc & req.stb & req.we & ~ack_reg;
    assign rd_en = req.cyc & req.stb & ~req.we & ~ack_reg;

    // an opcode written while one is in flight is dropped
    assign start = wr_hit(req, wr_en, `PSIO_OFS_INSN) && state_reg == psio_pkg::PSIO_IDLE;

    assign q4 = (q_reg == `PSIO_Q_LAST);

    // opcode fields of the held instruction
    assign is_subptr = (insn_reg[15:8] == `PSIO_OP_SUBPTR); // see RULE_01
    assign sel_field = insn_reg[7:6];
    assign lit       = insn_reg[5:0];
    // select 11 always lands on the frame pointer
    assign tgt_idx   = (sel_field == `PSIO_SEL_FRAME) ? `PSIO_FRAME_IDX : sel_field; // see RULE_03

    // borrow ripples from the low byte into the high nibble
    assign {lo_borrow, lo_diff} = {1'b0, ptr_reg[tgt_idx][7:0]} - {3'h0, lit}; // see RULE_13
    assign sub_result = {ptr_reg[tgt_idx][11:8] - {3'h0, lo_borrow}, lo_diff}; // see RULE_13 see RULE_01

    psio_addr_map u_addr_map (
        .opcode_i    (insn_reg),
        .ext_en_i    (ext_en_reg), // see RULE_05
        .bank_sel_i  (bank_sel_reg),
        .frame_ptr_i (ptr_reg[`PSIO_FRAME_IDX]),
        .ea_o        (ea_comb)
    );

    // free-running q phase, four clocks per instruction cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= 2'h0;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            psio_pkg::PSIO_IDLE: begin
                if (start) begin
                    state_next = psio_pkg::PSIO_WAIT;
                end
            end
            psio_pkg::PSIO_WAIT: begin
                // execution aligns to the next instruction cycle
                if (q4) begin
                    state_next = psio_pkg::PSIO_EXEC;
                end
            end
            psio_pkg::PSIO_EXEC: begin
                if (q4) begin
                    if (is_subptr && sel_field == `PSIO_SEL_FRAME) begin
                        state_next = psio_pkg::PSIO_NOP; // see RULE_04
                    end else begin
                        state_next = psio_pkg::PSIO_IDLE; // see RULE_02
                    end
                end
            end
            psio_pkg::PSIO_NOP: begin
                // second cycle of subtract-and-return does nothing
                if (q4) begin
                    state_next = psio_pkg::PSIO_IDLE; // see RULE_04
                end
            end
            default: begin
                state_next = psio_pkg::PSIO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= psio_pkg::PSIO_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            insn_reg <= 16'h0000;
        end else if (start) begin
            insn_reg <= 16'(wb_merge({16'h0000, insn_reg}, req.dat, req.sel));
        end
    end

    // one bit enables indexed addressing; the pointer-subtract opcodes run whatever its value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_en_reg <= `PSIO_CTRL_RESET; // see RULE_12
        end else if (wr_hit(req, wr_en, `PSIO_OFS_CTRL) && req.sel[0]) begin
            ext_en_reg <= req.dat[`PSIO_CTRL_EXT_BIT]; // see RULE_05
        end
    end

    // pointer writeback at q4 of the execute cycle beats a software write
    for (genvar gi = 0; gi < 3; gi++) begin : g_ptr
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ptr_reg[gi] <= '0;
            end else if (state_reg == psio_pkg::PSIO_EXEC && q4 && is_subptr && tgt_idx == 2'(gi)) begin
                ptr_reg[gi] <= sub_result; // see RULE_01 see RULE_03 see RULE_04
            end else if (wr_hit(req, wr_en, `PSIO_OFS_PTR0 + 8'(gi * 4))) begin
                ptr_reg[gi] <= (`PSIO_PTR_W)'(wb_merge({20'h00000, ptr_reg[gi]}, req.dat, req.sel));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stack_top_reg <= '0;
        end else if (wr_hit(req, wr_en, `PSIO_OFS_STACK_TOP)) begin
            stack_top_reg <= (`PSIO_PC_W)'(wb_merge({11'h000, stack_top_reg}, req.dat, req.sel));
        end
    end

    // return loads the program counter from the stack top
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= '0;
        end else if (state_reg == psio_pkg::PSIO_EXEC && q4 && is_subptr && sel_field == `PSIO_SEL_FRAME) begin
            pc_reg <= stack_top_reg; // see RULE_04
        end else if (wr_hit(req, wr_en, `PSIO_OFS_PC)) begin
            pc_reg <= (`PSIO_PC_W)'(wb_merge({11'h000, pc_reg}, req.dat, req.sel));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ret_reg <= 1'b0;
        end else if (state_reg == psio_pkg::PSIO_EXEC && q4) begin
            ret_reg <= is_subptr && sel_field == `PSIO_SEL_FRAME;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_sel_reg <= 4'h0;
        end else if (wr_hit(req, wr_en, `PSIO_OFS_BANK_SEL) && req.sel[0]) begin
            bank_sel_reg <= req.dat[3:0];
        end
    end

    // arithmetic flags are only ever changed by software here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else if (wr_hit(req, wr_en, `PSIO_OFS_STATUS) && req.sel[0]) begin
            flags_reg <= req.dat[`PSIO_FLAGS_W-1:0]; // see RULE_02
        end
    end

    // resolved operand address, captured at q4 of the execute cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ea_reg <= '0;
        end else if (state_reg == psio_pkg::PSIO_EXEC && q4) begin
            ea_reg <= ea_comb; // see RULE_07 see RULE_10
        end
    end

    always_comb begin
        rdat_next = 32'h0000_0000;
        case ({req.adr[7:2], 2'h0})
            `PSIO_OFS_CTRL: begin
                rdat_next[`PSIO_CTRL_EXT_BIT] = ext_en_reg;
            end
            `PSIO_OFS_INSN: begin
                rdat_next[15:0] = insn_reg;
            end
            `PSIO_OFS_PTR0: begin
                rdat_next[`PSIO_PTR_W-1:0] = ptr_reg[0];
            end
            `PSIO_OFS_PTR1: begin
                rdat_next[`PSIO_PTR_W-1:0] = ptr_reg[1];
            end
            `PSIO_OFS_PTR2: begin
                rdat_next[`PSIO_PTR_W-1:0] = ptr_reg[2];
            end
            `PSIO_OFS_STACK_TOP: begin
                rdat_next[`PSIO_PC_W-1:0] = stack_top_reg;
            end
            `PSIO_OFS_PC: begin
                rdat_next[`PSIO_PC_W-1:0] = pc_reg;
            end
            `PSIO_OFS_BANK_SEL: begin
                rdat_next[3:0] = bank_sel_reg;
            end
            `PSIO_OFS_STATUS: begin
                rdat_next[`PSIO_FLAGS_W-1:0]  = flags_reg;
                rdat_next[`PSIO_ST_BUSY_BIT]  = (state_reg != psio_pkg::PSIO_IDLE);
                rdat_next[`PSIO_ST_RET_BIT]   = ret_reg;
            end
            `PSIO_OFS_EA: begin
                rdat_next[11:0]               = ea_reg.addr;
                rdat_next[`PSIO_EA_IDX_BIT]   = ea_reg.indexed;
                rdat_next[`PSIO_EA_DESTW_BIT] = ea_reg.dest_w;
                rdat_next[`PSIO_EA_VALID_BIT] = ea_reg.valid;
            end
            default: begin
                // unmapped words read as zero and still acknowledge
                rdat_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wr_en | rd_en;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o   = ack_reg;
    assign wb_dat_o   = rdat_reg;
    assign ext_en_o   = ext_en_reg;
    assign pc_o       = pc_reg;
    assign ea_addr_o  = ea_reg.addr;
    assign ea_valid_o = ea_reg.valid;

    // busy mirrors the state register through a flip-flop of its own
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_next != psio_pkg::PSIO_IDLE);
        end
    end
endmodule

// [tb/psio_top_props.sv]
// concurrent checks on the pointer-subtract decoder ports
`timescale 1ns/100ps
module psio_top_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        busy_o,
    input wire logic        ext_en_o,
    input wire logic [20:0] pc_o,
    input wire logic [11:0] ea_addr_o,
    input wire logic        ea_valid_o
);
    logic take;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_follows_req: assert property (take |=> wb_ack_o) else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ext_from_ctrl: assert property (take && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0]
        |=> ext_en_o == $past(wb_dat_i[0])) else $error("enable does not follow control write");
    a_reset_clean: assert property ($fell(rst_i) |-> !ext_en_o && !busy_o && pc_o == 21'h0)
        else $error("state not cleared by reset");
    a_busy_on_insn: assert property (take && wb_we_i && wb_adr_i[7:2] == 6'h01 && !busy_o
        |-> ##[1:2] busy_o) else $error("opcode write did not start execution");
    a_busy_bounded: assert property ($rose(busy_o) |-> busy_o[*4] ##[0:9] !busy_o)
        else $error("execution length out of range");
    a_pc_has_cause: assert property ($changed(pc_o)
        |-> $past(busy_o) || $past(take && wb_we_i && wb_adr_i[7:2] == 6'h06)) else $error("pc moved without cause");
    a_ctrl_readback: assert property (take && !wb_we_i && wb_adr_i[7:2] == 6'h00
        |=> wb_dat_o == {31'h0, ext_en_o}) else $error("control read mismatch");
    a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i[7:2] > 6'h09 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_ea_at_exec: assert property ($changed(ea_addr_o) || $changed(ea_valid_o) |-> $past(busy_o))
        else $error("operand address moved outside execution");
endmodule

bind psio_top psio_top_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy_o(busy_o), .ext_en_o(ext_en_o), .pc_o(pc_o), .ea_addr_o(ea_addr_o),
    .ea_valid_o(ea_valid_o));

// [tb/test_psio_top.sv]
// self-checking bench for the pointer-subtract decoder
`timescale 1ns/100ps
module test_psio_top;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        busy_o;
    logic        ext_en_o;
    logic [20:0] pc_o;
    logic [11:0] ea_addr_o;
    logic        ea_valid_o;
    int          fails       = 0;
    int          check_count = 0;
    logic [31:0] rd;
    // {ext, frame pointer, opcode, expected ea word}; bank select is 3 throughout
    localparam logic [63:0] EA_TAB [9] = '{64'h0a00242c0006002c, 64'h0a00232c0004032c, 64'h1a00242c00070a2c,
        64'h1a00262c00050a2c, 64'h1a00246000060f60, 64'h1a00245f00070a5f, 64'h1000242c0007002c,
        64'h1a008e0a00050a0a, 64'h1a00252c0006032c};
    // {select, start value, literal, expected}; borrow and wrap cases included
    localparam logic [35:0] SUB_TAB [3] = '{36'h0100010ff, 36'h13ff233dc, 36'h20103ffd1};

    psio_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .busy_o(busy_o), .ext_en_o(ext_en_o), .pc_o(pc_o), .ea_addr_o(ea_addr_o), .ea_valid_o(ea_valid_o));

    always #2.5 clk_i = ~clk_i;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("wb_ack", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_xfer(1'b1, adr, dat, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 32'h0, q);
        chk(name, exp, q);
    endtask

    // waits out the run on busy so expectations never depend on the q phase
    task automatic exec(input logic [15:0] op, input logic extra);
        int n;
        n = 0;
        wr(8'h04, {16'h0, op});
        if (extra) wr(8'h04, 32'h0000e901);
        while (busy_o !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk("busy_o", 32'h0, {31'h0, busy_o});
    endtask

    task automatic test_done();
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        fails++;
        $display("[FAIL] watchdog expected done seen hang");
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl", 8'h00, 32'h0);
        rd_chk("status", 8'h20, 32'h0);
        rd_chk("unmapped", 8'h3c, 32'h0);
        wr(8'h20, 32'h00000015);
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) wr(8'h08 + 8'(4 * j), (j == i) ? {20'h0, SUB_TAB[i][31:20]} : 32'h555);
            exec({8'he9, SUB_TAB[i][33:32], SUB_TAB[i][17:12]}, 1'b0);
            for (int j = 0; j < 3; j++) begin
                rd_chk("ptr", 8'h08 + 8'(4 * j), (j == i) ? {20'h0, SUB_TAB[i][11:0]} : 32'h555);
            end
            rd_chk("status", 8'h20, 32'h00000015);
        end
        wr(8'h08, 32'h555);
        wr(8'h0c, 32'h555);
        wr(8'h10, 32'h3ff);
        wr(8'h14, 32'h00012345);
        exec(16'he9e3, 1'b1);
        rd_chk("frame", 8'h10, 32'h3dc);
        rd_chk("ptr0", 8'h08, 32'h555);
        rd_chk("ptr1", 8'h0c, 32'h555);
        chk("pc_o", 32'h00012345, {11'h0, pc_o});
        rd_chk("status", 8'h20, 32'h00000215);
        rd_chk("insn", 8'h04, 32'h0000e9e3);
        chk("ea_valid_o", 32'h0, {31'h0, ea_valid_o});
        wb_sel_i <= 4'h1;
        wr(8'h18, 32'h00abcdef);
        wb_sel_i <= 4'hf;
        rd_chk("pc_lane", 8'h18, 32'h000123ef);
        wr(8'h1c, 32'h3);
        for (int i = 0; i < 9; i++) begin
            wr(8'h00, {31'h0, EA_TAB[i][60]});
            chk("ext_en_o", {31'h0, EA_TAB[i][60]}, {31'h0, ext_en_o});
            wr(8'h10, {20'h0, EA_TAB[i][59:48]});
            exec(EA_TAB[i][47:32], 1'b0);
            rd_chk("ea", 8'h24, EA_TAB[i][31:0]);
            chk("ea_addr_o", {20'h0, EA_TAB[i][11:0]}, {20'h0, ea_addr_o});
            chk("ea_valid_o", 32'h1, {31'h0, ea_valid_o});
        end
        wr(8'h00, 32'h1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("ctrl", 8'h00, 32'h0);
        rd_chk("frame", 8'h10, 32'h0);
        test_done();
    end
endmodule
